// ===== shared/sopc_pkg.sv
// package: constants and carriers for the strap option capture block
package sopc_pkg;
  // ----------------------------------------
  // i/o ports of the index/data pair
  // ----------------------------------------
  localparam logic [15:0] INDEX_PORT = 16'h0022;
  localparam logic [15:0] DATA_PORT = 16'h0023;
  // ----------------------------------------
  // register indices
  // ----------------------------------------
  localparam logic [7:0] IDX_CAPTURE_ZERO = 8'h4a;
  localparam logic [7:0] IDX_CAPTURE_TWO = 8'h4c;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
  // ----------------------------------------
  // data pin numbers feeding each strap
  // ----------------------------------------
  localparam int MD_WIDTH = 54;
  localparam int PIN_PLL_HI = 7;
  localparam int PIN_PLL_LO = 6;
  localparam int PIN_MODE_HI = 9;
  localparam int PIN_MODE_LO = 8;
  localparam int PIN_SYNC = 5;
  localparam int PIN_DIV_HI = 4;
  localparam int PIN_DIV_LO = 17;
  localparam int PIN_SER_TWO = 50;
  localparam int PIN_SER_ONE = 51;
  localparam int PIN_KBD = 52;
  localparam int PIN_PAR = 53;
  // ----------------------------------------
  // capture timing after reset release
  // ----------------------------------------
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] SETTLE_COUNT = 2'h3;
  // ----------------------------------------
  // strap codes
  // ----------------------------------------
  localparam logic [1:0] MODE_ISA = 2'h0;
  localparam logic [1:0] MODE_PCMCIA = 2'h1;
  localparam logic [1:0] MODE_LOCAL = 2'h2;
  localparam logic [2:0] DIV_FOUR = 3'h4;
  localparam logic [2:0] DIV_THREE = 3'h3;
  localparam logic [2:0] DIV_TWO = 3'h2;
  // ----------------------------------------
  // captured strap set
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] pll_range;
    logic [1:0] bus_mode;
    logic mem_sync;
    logic div_hi;
    logic div_lo;
    logic ser_two;
    logic ser_one;
    logic kbd;
    logic par;
  } sopc_straps_s;
  localparam sopc_straps_s STRAPS_RESET = '0;
endpackage

// ===== rtl/sopc_capture.sv
// strap option capture: latches board straps and serves them over the index/data port
`timescale 1ns/1ps
module sopc_capture (
  input wire logic clock,
  input wire logic rst_n,
  // board strap levels on the shared memory data pins
  input wire logic [sopc_pkg::MD_WIDTH-1:0] memory_data_strap_pin,
  // i/o access from the processor side
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rdata_valid,
  // strap-derived controls
  output logic straps_valid,
  output logic [1:0] pll_range,
  output logic pll_range_reserved,
  output logic isa_enable,
  output logic pcmcia_enable,
  output logic local_bus_enable,
  output logic bus_mode_reserved,
  output logic mem_clock_sync,
  output logic peripheral_bus_clock,
  output logic second_serial_enable,
  output logic first_serial_enable,
  output logic keyboard_mouse_enable,
  output logic parallel_port_enable
);

  // ----------------------------------------
  // byte image of a strap register
  // ----------------------------------------
  function automatic logic [7:0] reg_image(
    input logic [7:0] idx,
    input sopc_pkg::sopc_straps_s s
  );
    logic [7:0] v;
    v = sopc_pkg::UNMAPPED_VALUE;
    if (idx == sopc_pkg::IDX_CAPTURE_ZERO) begin
      // bit 3 reserved reads zero
      v = {s.pll_range, s.bus_mode, 1'b0, s.mem_sync, s.div_hi, s.div_lo};
    end else if (idx == sopc_pkg::IDX_CAPTURE_TWO) begin
      // only serial, keyboard and parallel bits held here
      v = {s.par, s.kbd, 4'h0, s.ser_one, s.ser_two};
    end
    return v;
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [sopc_pkg::MD_WIDTH-1:0] pin_meta; // first sync stage
  logic [sopc_pkg::MD_WIDTH-1:0] pin_sync; // second sync stage
  logic [1:0] settle_cnt; // cycles since reset release
  logic captured; // straps latched once
  sopc_pkg::sopc_straps_s straps; // held strap set
  sopc_pkg::sopc_straps_s next_straps; // decoded from pins
  logic [7:0] index_reg; // current register index
  logic [2:0] div_ratio; // selected divide ratio
  logic [2:0] div_cnt; // divider phase
  logic [2:0] next_div_cnt; // next divider phase
  logic div_high; // divider output level

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  // straps come from the board, two flops before use
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= memory_data_strap_pin;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------
  // settle counter
  // ----------------------------------------
  // waits for fresh samples to pass the synchroniser
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt <= '0;
    end else if (settle_cnt != sopc_pkg::SETTLE_COUNT) begin
      settle_cnt <= settle_cnt + 2'h1;
    end
  end

  // ----------------------------------------
  // strap decode from synchronised pins
  // ----------------------------------------
  always_comb begin
    next_straps = sopc_pkg::STRAPS_RESET;
    next_straps.pll_range = {pin_sync[sopc_pkg::PIN_PLL_HI], pin_sync[sopc_pkg::PIN_PLL_LO]};
    next_straps.bus_mode = {pin_sync[sopc_pkg::PIN_MODE_HI], pin_sync[sopc_pkg::PIN_MODE_LO]};
    next_straps.mem_sync = pin_sync[sopc_pkg::PIN_SYNC];
    next_straps.div_hi = pin_sync[sopc_pkg::PIN_DIV_HI];
    next_straps.div_lo = pin_sync[sopc_pkg::PIN_DIV_LO];
    next_straps.ser_two = pin_sync[sopc_pkg::PIN_SER_TWO];
    next_straps.ser_one = pin_sync[sopc_pkg::PIN_SER_ONE];
    next_straps.kbd = pin_sync[sopc_pkg::PIN_KBD];
    next_straps.par = pin_sync[sopc_pkg::PIN_PAR];
  end

  // ----------------------------------------
  // one-time capture
  // ----------------------------------------
  // single sampling point, then held until next reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      straps <= sopc_pkg::STRAPS_RESET;
      captured <= 1'b0;
    end else if (!captured && settle_cnt == sopc_pkg::SETTLE_COUNT) begin
      straps <= next_straps;
      captured <= 1'b1;
    end
  end

  // ----------------------------------------
  // index register
  // ----------------------------------------
  // written through the index port; data port writes change nothing
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      index_reg <= sopc_pkg::INDEX_RESET;
    end else if (io_wr && io_addr == sopc_pkg::INDEX_PORT) begin
      index_reg <= io_wdata;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // data answered one cycle after the read strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= '0;
      io_rdata_valid <= 1'b0;
    end else begin
      io_rdata_valid <= 1'b0;
      if (io_rd && io_addr == sopc_pkg::DATA_PORT) begin
        // strap byte through the data port
        io_rdata <= reg_image(index_reg, straps);
        io_rdata_valid <= 1'b1;
      end else if (io_rd && io_addr == sopc_pkg::INDEX_PORT) begin
        // index readback
        io_rdata <= index_reg;
        io_rdata_valid <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // pll range and synchronisation controls
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pll_range <= '0;
      pll_range_reserved <= 1'b0;
      mem_clock_sync <= 1'b0;
      straps_valid <= 1'b0;
    end else begin
      pll_range <= straps.pll_range;
      pll_range_reserved <= straps.pll_range[1];
      mem_clock_sync <= straps.mem_sync;
      straps_valid <= captured;
    end
  end

  // ----------------------------------------
  // expansion bus selection
  // ----------------------------------------
  // one-hot enables, none while uncaptured or reserved
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      isa_enable <= 1'b0;
      pcmcia_enable <= 1'b0;
      local_bus_enable <= 1'b0;
      bus_mode_reserved <= 1'b0;
    end else begin
      isa_enable <= captured && straps.bus_mode == sopc_pkg::MODE_ISA;
      pcmcia_enable <= captured && straps.bus_mode == sopc_pkg::MODE_PCMCIA;
      local_bus_enable <= captured && straps.bus_mode == sopc_pkg::MODE_LOCAL;
      bus_mode_reserved <= captured && straps.bus_mode == 2'h3;
    end
  end

  // ----------------------------------------
  // peripheral enables
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      second_serial_enable <= 1'b0;
      first_serial_enable <= 1'b0;
      keyboard_mouse_enable <= 1'b0;
      parallel_port_enable <= 1'b0;
    end else begin
      second_serial_enable <= straps.ser_two;
      first_serial_enable <= straps.ser_one;
      keyboard_mouse_enable <= straps.kbd;
      parallel_port_enable <= straps.par;
    end
  end

  // ----------------------------------------
  // peripheral bus clock divider
  // ----------------------------------------
  // upper strap low gives 4, else lower picks 3 or 2
  always_comb begin
    if (!straps.div_hi) begin
      div_ratio = sopc_pkg::DIV_FOUR;
    end else if (!straps.div_lo) begin
      div_ratio = sopc_pkg::DIV_THREE;
    end else begin
      div_ratio = sopc_pkg::DIV_TWO;
    end
    if (div_cnt >= div_ratio - 3'h1) begin
      next_div_cnt = '0;
    end else begin
      next_div_cnt = div_cnt + 3'h1;
    end
    // high for the first half of each period, one of three cycles at ratio 3
    div_high = next_div_cnt < (div_ratio >> 1);
  end

  // divider runs only once straps are known
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
      peripheral_bus_clock <= 1'b0;
    end else if (captured) begin
      div_cnt <= next_div_cnt;
      peripheral_bus_clock <= div_high;
    end
  end

endmodule

// ===== verif/sopc_board.sv
// board strap resistor model for the strap option capture block
`timescale 1ns/1ps
module sopc_board (
  input wire logic [10:0] user_straps, // {53,52,51,50,9,8,7,6,5,4,17}
  output logic [53:0] memory_data_strap_pin,
  output logic terminal_count_pin,
  output logic [2:0] dma_ack_encode_pins
);
  // unused pins sit on pull-ups, user straps drive their pins directly
  always_comb begin
    memory_data_strap_pin = '1;
    {memory_data_strap_pin[53:50], memory_data_strap_pin[9:4], memory_data_strap_pin[17]} = user_straps;
  end
  // reserved dma and count straps always pulled high
  assign terminal_count_pin = 1'b1;
  assign dma_ack_encode_pins = 3'h7;
endmodule

// ===== verif/sopc_capture_chk.sv
// checker: port-level properties of the strap capture block
`timescale 1ns/1ps
module sopc_capture_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [53:0] memory_data_strap_pin,
  input wire logic [15:0] io_addr,
  input wire logic io_rd,
  input wire logic io_rdata_valid,
  input wire logic straps_valid,
  input wire logic [1:0] pll_range,
  input wire logic pll_range_reserved,
  input wire logic isa_enable,
  input wire logic pcmcia_enable,
  input wire logic local_bus_enable,
  input wire logic bus_mode_reserved,
  input wire logic peripheral_bus_clock
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic hit; // read of one of the two ports
  logic dv, dhi, dlo; // divisor straps seen at capture
  assign hit = io_rd && (io_addr == sopc_pkg::INDEX_PORT || io_addr == sopc_pkg::DATA_PORT);
  // remember divisor straps when capture completes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dv <= 1'b0;
      dhi <= 1'b0;
      dlo <= 1'b0;
    end else if ($rose(straps_valid)) begin
      dv <= 1'b1;
      dhi <= memory_data_strap_pin[4];
      dlo <= memory_data_strap_pin[17];
    end
  end
  sequence s_lo2;
    !peripheral_bus_clock [*2];
  endsequence
  property p_rd_ans; hit |=> io_rdata_valid; endproperty
  property p_rd_ref; !hit |=> !io_rdata_valid; endproperty
  property p_pll_res; $rose(straps_valid) |-> pll_range_reserved == memory_data_strap_pin[7]; endproperty
  property p_bus_one; straps_valid |-> $onehot({isa_enable, pcmcia_enable, local_bus_enable, bus_mode_reserved}); endproperty
  property p_idle; !straps_valid |-> !(isa_enable || pcmcia_enable || local_bus_enable); endproperty
  property p_hold;
    straps_valid && $past(straps_valid) |-> $stable({pll_range, isa_enable, pcmcia_enable, local_bus_enable});
  endproperty
  property p_cap; $rose(straps_valid) |-> pll_range == memory_data_strap_pin[7:6]; endproperty
  property p_div;
    dv && $rose(peripheral_bus_clock) |=>
      if (!dhi) (peripheral_bus_clock ##1 s_lo2 ##1 peripheral_bus_clock)
      else if (dlo) (!peripheral_bus_clock ##1 peripheral_bus_clock)
      else (s_lo2 ##1 peripheral_bus_clock);
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read without answer");
  a_rd_ref: assert property (p_rd_ref) else $error("answer without read");
  a_pll_res: assert property (p_pll_res) else $error("pll reserved flag wrong");
  a_bus_one: assert property (p_bus_one) else $error("bus enables not one-hot");
  a_idle: assert property (p_idle) else $error("bus enabled before capture");
  a_hold: assert property (p_hold) else $error("straps changed after capture");
  a_cap: assert property (p_cap) else $error("pll range not from pins");
  a_div: assert property (p_div) else $error("bus clock shape wrong");
endmodule
bind sopc_capture sopc_capture_chk i_chk (.clock(clock), .rst_n(rst_n), .memory_data_strap_pin(memory_data_strap_pin),
  .io_addr(io_addr), .io_rd(io_rd), .io_rdata_valid(io_rdata_valid), .straps_valid(straps_valid),
  .pll_range(pll_range), .pll_range_reserved(pll_range_reserved), .isa_enable(isa_enable),
  .pcmcia_enable(pcmcia_enable), .local_bus_enable(local_bus_enable), .bus_mode_reserved(bus_mode_reserved),
  .peripheral_bus_clock(peripheral_bus_clock));

// ===== verif/test_strap_option_capture.sv
// testbench: strap patterns, register reads and derived controls
`timescale 1ns/1ps
module test_strap_option_capture;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [10:0] st = 11'h000; // strap pattern for the board
  logic [53:0] md;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  logic [1:0] pll_range;
  logic io_rdata_valid, straps_valid, pll_res, isa, pcm, lcl, bres, sync, pbc, ser2, ser1, kbd, par;
  int n_fail = 0;
  int total_checks = 0;
  logic [10:0] pats [4] = '{11'h004, 11'h52a, 11'h2d7, 11'h7f9}; // all modes and divisors
  initial forever #2.5 clock = ~clock;
  sopc_board i_board (.user_straps(st), .memory_data_strap_pin(md), .terminal_count_pin(), .dma_ack_encode_pins());
  sopc_capture i_dut (.clock(clock), .rst_n(rst_n), .memory_data_strap_pin(md), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
    .straps_valid(straps_valid), .pll_range(pll_range), .pll_range_reserved(pll_res), .isa_enable(isa),
    .pcmcia_enable(pcm), .local_bus_enable(lcl), .bus_mode_reserved(bres), .mem_clock_sync(sync),
    .peripheral_bus_clock(pbc), .second_serial_enable(ser2), .first_serial_enable(ser1),
    .keyboard_mouse_enable(kbd), .parallel_port_enable(par));
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle strobe, then one idle edge
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
    io_wr = wr;
    io_rd = !wr;
    io_addr = a;
    io_wdata = d;
    @(posedge clock);
    #1;
    io_wr = 1'b0;
    io_rd = 1'b0;
    @(posedge clock);
    #1;
  endtask
  // one-cycle read strobe, answer checked while its valid pulse stands
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    io_rd = 1'b1;
    io_addr = a;
    @(posedge clock);
    #1;
    io_rd = 1'b0;
    chk({7'h00, io_rdata_valid}, 8'h01);
    chk(io_rdata, exp);
    @(posedge clock);
    #1;
    chk({7'h00, io_rdata_valid}, 8'h00);
  endtask
  // rising edges of the bus clock over twelve cycles
  task automatic rises(output int n);
    logic p;
    n = 0;
    p = pbc;
    repeat (12) begin
      @(posedge clock);
      #1;
      if (pbc && !p) n++;
      p = pbc;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    #50000;
    n_fail++;
    report_and_stop();
  end
  // main sequence: one reset per strap pattern
  initial begin
    logic [7:0] e0, e2;
    int r;
    foreach (pats[i]) begin
      st = pats[i];
      rst_n = 1'b0;
      repeat (16) @(posedge clock);
      #1 rst_n = 1'b1;
      for (r = 0; r < 20 && straps_valid !== 1'b1; r++) begin
        @(posedge clock);
        #1;
      end
      chk({7'h00, straps_valid}, 8'h01);
      e0 = {st[4], st[3], st[6], st[5], 1'b0, st[2], st[1], st[0]};
      e2 = {st[10], st[9], 4'h0, st[8], st[7]};
      acc(1'b1, sopc_pkg::INDEX_PORT, sopc_pkg::IDX_CAPTURE_ZERO);
      rd(sopc_pkg::DATA_PORT, e0);
      acc(1'b1, sopc_pkg::DATA_PORT, ~e0);
      rd(sopc_pkg::DATA_PORT, e0);
      rd(sopc_pkg::INDEX_PORT, sopc_pkg::IDX_CAPTURE_ZERO);
      acc(1'b1, sopc_pkg::INDEX_PORT, sopc_pkg::IDX_CAPTURE_TWO);
      rd(sopc_pkg::DATA_PORT, e2);
      acc(1'b1, sopc_pkg::INDEX_PORT, 8'h4b);
      rd(sopc_pkg::DATA_PORT, 8'h00);
      chk({4'h0, bres, lcl, pcm, isa}, 8'h01 << {st[6], st[5]});
      chk({5'h00, pll_res, pll_range}, {5'h00, st[4], st[4], st[3]});
      chk({4'h0, par, kbd, ser1, ser2}, {4'h0, st[10:7]});
      chk({7'h00, sync}, {7'h00, st[2]});
      rises(r);
      chk(r[7:0], st[1] ? (st[0] ? 8'h06 : 8'h04) : 8'h03);
      st = ~st;
      repeat (8) @(posedge clock);
      #1;
      acc(1'b1, sopc_pkg::INDEX_PORT, sopc_pkg::IDX_CAPTURE_ZERO);
      rd(sopc_pkg::DATA_PORT, e0);
    end
    report_and_stop();
  end
endmodule
